// ---- pkg/lhp_pkg.sv ----
// package for the lcd host port and ram addressing block
// Notes on behaviour
// RULE_01: two straps choose serial, separate-strobe, enable-strobe bus, or hold in reset.
// RULE_02: for enable-strobe bus the high strap must rise first or together.
// RULE_03: select and strobes decode to data read, data write, status read, command.
// RULE_04: serial receiver is 8-bit shifter plus 3-bit counter, live only when selected.
// RULE_05: deselecting clears shifter and counter, discarding a partial byte.
// RULE_06: serial bits arrive msb first, sampled on rising serial clock.
// RULE_07: every eighth rising serial edge yields one byte that gets processed.
// RULE_08: data/command select sampled on eighth edge: high data, low command.
// RULE_09: serial mode is write-only; no ram or status readback.
// RULE_10: when not selected the data bus floats and select and strobes are ignored.
// RULE_11: reset acts regardless of chip select; otherwise state holds until reset.
// RULE_12: writes go through a bus holder (code writes ram directly from the bus); reads return what holder fetched before.
// RULE_13: first data read after address set or write returns stale holder data.
// RULE_14: busy flag raised during operations; only status read accepted; busy on bit 7.
// RULE_15: start-line command loads 5 bits; line counter preset on each frame signal toggle.
// RULE_16: line counter steps on oscillator in master mode, line clock in slave mode.
// RULE_17: column is 7-bit presettable counter, +1 per data read or write, holding at top column, page independent.
// RULE_18: column set above top column locks the counter until next column set.
// RULE_19: column command presets column, page command loads page, nothing else touched.
// RULE_20: segment-direction select reverses column to segment mapping, data untouched.
// RULE_21: page is 4-bit register; page 4 is indicator row storing only bit 0.
// RULE_22: refresh reads run on display clock and are undisturbed by host writes.
// RULE_23: frame signal derived from display clock, alternating polarity over two frames.
package lhp_pkg;
  localparam int unsigned LHP_COLS = 80;
  localparam logic [6:0] LHP_COL_TOP = 7'h4f;
  localparam int unsigned LHP_PAGES = 5;
  localparam logic [3:0] LHP_IND_PAGE = 4'h4;
  localparam int unsigned LHP_LINES = 32;
  localparam int unsigned LHP_OSC_DIV = 16;
  localparam logic [2:0] LHP_BUSY_CYC = 3'h2;
  // command encodings
  localparam logic [7:0] LHP_CMD_START_MASK = 8'he0;
  localparam logic [7:0] LHP_CMD_START = 8'hc0;
  localparam logic [7:0] LHP_CMD_PAGE_MASK = 8'hfc;
  localparam logic [7:0] LHP_CMD_PAGE = 8'hb8;
  localparam logic [7:0] LHP_CMD_COL_MASK = 8'h80;
  localparam logic [7:0] LHP_CMD_COL = 8'h00;
  localparam logic [7:0] LHP_CMD_ADC_MASK = 8'hfe;
  localparam logic [7:0] LHP_CMD_ADC = 8'ha0;
  localparam logic [7:0] LHP_CMD_IND = 8'hbc;
  typedef enum logic [3:0] {
    LHP_BUS_RESET = 4'b0001,
    LHP_BUS_SEP = 4'b0010,
    LHP_BUS_ENA = 4'b0100,
    LHP_BUS_SER = 4'b1000
  } lhp_bus_t;
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } lhp_byte_t;
endpackage : lhp_pkg

// ---- hw/lhp_port.sv ----
// host port, address counters and display-side line counter
`timescale 1ns/100ps
module lhp_port
  import lhp_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic srst_in, // sync reset
  input wire logic disp_clk_in, // display clock domain
  input wire logic disp_rst_in, // sync reset, display domain
  input wire logic bus_strap_hi_in, // strap, high order
  input wire logic bus_strap_lo_in, // strap, low order
  input wire logic chip_select_low_active_n_in, // active-low select
  input wire logic chip_select_high_active_in, // active-high select
  input wire logic data_command_select_in, // 1 data, 0 command
  input wire logic rd_e_in, // read strobe low / enable
  input wire logic wr_rw_in, // write strobe low / read-not-write
  input wire logic [7:0] data_in, // data pins; bit6 sclk, bit7 sdata
  input wire logic master_mode_in, // 1 internal oscillator
  input wire logic line_clock_input_in, // line clock for slave mode
  output logic [7:0] data_out, // data pins driven value
  output logic data_oe_out, // data pins enable
  output logic frame_ac_signal_out, // frame ac
  output logic [4:0] line_addr_out, // current refresh line
  output logic [7:0] latch_out, // refresh byte for the driver latch
  output logic seg_reverse_out, // segment direction
  output logic [6:0] column_out, // column counter
  output logic [3:0] page_out, // page register
  output logic busy_out // busy flag
);
  ////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] sh_s1_r, sh_s2_r;
  logic [2:0] pin_s1_r, pin_s2_r;
  logic [1:0] d_s1_r, d_s2_r;
  always_ff @(posedge core_clk_in)
  begin
    sh_s1_r <= {bus_strap_lo_in, bus_strap_hi_in};
    sh_s2_r <= sh_s1_r;
    pin_s1_r <= {chip_select_low_active_n_in, chip_select_high_active_in, data_command_select_in};
    pin_s2_r <= pin_s1_r;
    d_s1_r <= {rd_e_in, wr_rw_in};
    d_s2_r <= d_s1_r;
  end
  logic [7:0] din_s1_r, din_s2_r;
  always_ff @(posedge core_clk_in)
  begin
    din_s1_r <= data_in;
    din_s2_r <= din_s1_r;
  end
  logic sel, a0;
  assign sel = !pin_s2_r[2] && pin_s2_r[1]; // RULE_10
  assign a0 = pin_s2_r[0];
  lhp_bus_t bus_mode;
  always_comb
  begin
    case (sh_s2_r[1:0])
      2'b01: bus_mode = LHP_BUS_SER; // RULE_01
      2'b10: bus_mode = LHP_BUS_SEP;
      2'b11: bus_mode = LHP_BUS_ENA;
      default: bus_mode = LHP_BUS_RESET;
    endcase
  end
  logic port_rst;
  assign port_rst = srst_in || bus_mode == LHP_BUS_RESET; // RULE_01 RULE_11
  ////////////////////////////////////////////////////////////////
  // parallel strobe decode, one pulse per access
  logic rd_act, wr_act, acc_act, acc_prev_r;
  always_comb
  begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (sel && bus_mode == LHP_BUS_SEP) // RULE_03
    begin
      rd_act = !d_s2_r[1] && d_s2_r[0];
      wr_act = d_s2_r[1] && !d_s2_r[0];
    end
    else if (sel && bus_mode == LHP_BUS_ENA)
    begin
      rd_act = d_s2_r[1] && d_s2_r[0];
      wr_act = d_s2_r[1] && !d_s2_r[0];
    end
  end
  assign acc_act = rd_act || wr_act;
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
      acc_prev_r <= 1'b0;
    else
      acc_prev_r <= acc_act;
  end
  logic acc_start, rd_start, wr_start;
  assign acc_start = acc_act && !acc_prev_r;
  assign rd_start = acc_start && rd_act;
  assign wr_start = acc_start && wr_act;
  ////////////////////////////////////////////////////////////////
  // serial receiver: sclk on bit 6, sdata on bit 7
  logic [7:0] sh_r;
  logic [2:0] bcnt_r;
  logic sclk_prev_r;
  lhp_byte_t ser_byte_r;
  logic ser_vld_r;
  logic ser_on, sclk_rise;
  assign ser_on = sel && bus_mode == LHP_BUS_SER; // RULE_04
  assign sclk_rise = din_s2_r[6] && !sclk_prev_r;
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst || !ser_on) // RULE_05
    begin
      sh_r <= 8'h00;
      bcnt_r <= 3'h0;
      sclk_prev_r <= 1'b0;
      ser_vld_r <= 1'b0;
      ser_byte_r <= '0;
    end
    else
    begin
      sclk_prev_r <= din_s2_r[6];
      ser_vld_r <= 1'b0;
      if (sclk_rise)
      begin
        sh_r <= {sh_r[6:0], din_s2_r[7]}; // RULE_06
        bcnt_r <= bcnt_r + 3'h1;
        if (bcnt_r == 3'h7) // RULE_07
        begin
          ser_byte_r <= '{is_data: a0, value: {sh_r[6:0], din_s2_r[7]}}; // RULE_08
          ser_vld_r <= 1'b1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // busy, commands and address counters
  logic [2:0] busy_r;
  assign busy_out = busy_r != 3'h0; // RULE_14
  logic cmd_go, dwr_go, drd_go;
  logic [7:0] cval;
  assign cval = ser_vld_r ? ser_byte_r.value : din_s2_r;
  assign cmd_go = !busy_out && ((wr_start && !a0) || (ser_vld_r && !ser_byte_r.is_data)); // RULE_03 RULE_14
  assign dwr_go = !busy_out && ((wr_start && a0) || (ser_vld_r && ser_byte_r.is_data));
  assign drd_go = !busy_out && rd_start && a0 && bus_mode != LHP_BUS_SER; // RULE_09
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
      busy_r <= 3'h0;
    else if (cmd_go || dwr_go || drd_go)
      busy_r <= LHP_BUSY_CYC;
    else if (busy_out)
      busy_r <= busy_r - 3'h1;
  end
  logic [6:0] col_r;
  logic col_lock_r;
  logic [3:0] page_r;
  logic [4:0] start_r;
  logic adc_r;
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
    begin
      col_r <= 7'h00;
      col_lock_r <= 1'b0;
      page_r <= 4'h0;
      start_r <= 5'h00;
      adc_r <= 1'b0;
    end
    else if (cmd_go)
    begin
      if ((cval & LHP_CMD_COL_MASK) == LHP_CMD_COL) // RULE_19
      begin
        col_r <= cval[6:0];
        col_lock_r <= cval[6:0] > LHP_COL_TOP; // RULE_18
      end
      else if ((cval & LHP_CMD_PAGE_MASK) == LHP_CMD_PAGE)
        page_r <= {2'b00, cval[1:0]}; // RULE_21
      else if ((cval & LHP_CMD_START_MASK) == LHP_CMD_START)
        start_r <= cval[4:0]; // RULE_15
      else if ((cval & LHP_CMD_ADC_MASK) == LHP_CMD_ADC)
        adc_r <= cval[0]; // RULE_20
      else if (cval == LHP_CMD_IND)
        page_r <= LHP_IND_PAGE; // RULE_21
    end
    else if ((dwr_go || drd_go) && !col_lock_r)
      col_r <= (col_r == LHP_COL_TOP) ? col_r : col_r + 7'h01; // RULE_17
  end
  assign column_out = col_r;
  assign page_out = page_r;
  assign seg_reverse_out = adc_r;
  ////////////////////////////////////////////////////////////////
  // display ram and bus holder
  logic [7:0] ram_r [LHP_PAGES*LHP_COLS];
  logic [7:0] holder_r;
  logic [8:0] widx, hidx;
  assign widx = 9'(page_r) * 9'(LHP_COLS) + 9'(col_r);
  always_ff @(posedge core_clk_in)
  begin
    if (dwr_go && !col_lock_r && page_r <= LHP_IND_PAGE) // RULE_12
      ram_r[widx] <= (page_r == LHP_IND_PAGE) ? {7'h00, cval[0]} : cval; // RULE_21
  end
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
      holder_r <= 8'h00;
    else if (drd_go && !col_lock_r && page_r <= LHP_IND_PAGE)
      holder_r <= ram_r[widx]; // RULE_12 RULE_13
  end
  // bus output: holder on data read, busy on bit7 for status
  logic rd_hold;
  assign rd_hold = sel && rd_act && bus_mode != LHP_BUS_SER;
  logic [7:0] dout_r;
  logic oe_r;
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
    begin
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else
    begin
      oe_r <= rd_hold; // RULE_10 RULE_09
      if (rd_start)
        dout_r <= a0 ? holder_r : {busy_out, 7'h00}; // RULE_14 RULE_13
    end
  end
  assign data_out = dout_r;
  assign data_oe_out = oe_r;
  ////////////////////////////////////////////////////////////////
  // start line crossing: toggle handshake, word frozen while the toggle is in flight
  // core resends on every round trip, so a display-only reset relearns the value
  logic st_req_r, st_ack_s1_r, st_ack_s2_r, st_req_s1_r, st_req_s2_r, st_seen_r;
  logic [4:0] st_data_r, st_disp_r;
  always_ff @(posedge core_clk_in)
  begin
    st_ack_s1_r <= st_seen_r;
    st_ack_s2_r <= st_ack_s1_r;
  end
  always_ff @(posedge core_clk_in)
  begin
    if (port_rst)
    begin
      st_req_r <= 1'b0;
      st_data_r <= 5'h00;
    end
    else if (st_ack_s2_r == st_req_r)
    begin
      st_data_r <= start_r; // RULE_15
      st_req_r <= !st_req_r;
    end
  end
  always_ff @(posedge disp_clk_in)
  begin
    st_req_s1_r <= st_req_r;
    st_req_s2_r <= st_req_s1_r;
  end
  always_ff @(posedge disp_clk_in)
  begin
    if (disp_rst_in)
    begin
      st_seen_r <= 1'b0;
      st_disp_r <= 5'h00;
    end
    else if (st_req_s2_r != st_seen_r)
    begin
      st_seen_r <= st_req_s2_r;
      st_disp_r <= st_data_r; // RULE_15
    end
  end
  // display domain pins
  logic mm_s1_r, mm_s2_r, cl_s1_r, cl_s2_r, cl_prev_r;
  always_ff @(posedge disp_clk_in)
  begin
    mm_s1_r <= master_mode_in;
    mm_s2_r <= mm_s1_r;
    cl_s1_r <= line_clock_input_in;
    cl_s2_r <= cl_s1_r;
  end
  logic [3:0] osc_r;
  logic [4:0] line_r;
  logic fr_r;
  logic step;
  assign step = mm_s2_r ? (osc_r == 4'(LHP_OSC_DIV - 1)) : (cl_s2_r && !cl_prev_r); // RULE_16
  always_ff @(posedge disp_clk_in)
  begin
    if (disp_rst_in)
    begin
      osc_r <= 4'h0;
      cl_prev_r <= 1'b0;
      line_r <= 5'h00;
      fr_r <= 1'b0;
    end
    else
    begin
      osc_r <= osc_r + 4'h1;
      cl_prev_r <= cl_s2_r;
      if (step)
      begin
        if (line_r == 5'(LHP_LINES - 1))
        begin
          fr_r <= !fr_r; // RULE_23
          line_r <= st_disp_r; // RULE_15
        end
        else
          line_r <= line_r + 5'h01;
      end
    end
  end
  assign frame_ac_signal_out = fr_r;
  assign line_addr_out = line_r;
  // refresh read on its own clock; host writes never stall it
  logic [7:0] latch_r;
  always_ff @(posedge disp_clk_in)
  begin
    if (disp_rst_in)
      latch_r <= 8'h00;
    else if (step)
      latch_r <= ram_r[9'(line_r[4:3]) * 9'(LHP_COLS)]; // RULE_22
  end
  assign latch_out = latch_r;
  ////////////////////////////////////////////////////////////////
  lock_hold_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    col_lock_r && !cmd_go |=> $stable(col_r)) // RULE_18
    else $error("locked column moved");
  col_step_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    dwr_go && !col_lock_r && col_r < LHP_COL_TOP |=> col_r == $past(col_r) + 7'h01) // RULE_17
    else $error("column did not step");
  busy_len_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    $rose(busy_out) |-> busy_out [*2] ##1 !busy_out) // RULE_14
    else $error("busy length wrong");
  desel_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    !ser_on |=> bcnt_r == 3'h0 && sh_r == 8'h00) // RULE_05
    else $error("serial state not cleared");
  float_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    !sel |=> !data_oe_out) // RULE_10
    else $error("bus driven while unselected");
  ser_ro_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    bus_mode == LHP_BUS_SER |-> !drd_go) // RULE_09
    else $error("serial read accepted");
  byte_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    ser_on && sclk_rise && bcnt_r == 3'h7 |=> ser_vld_r) // RULE_07
    else $error("byte not produced");
  fr_a: assert property (@(posedge disp_clk_in) disable iff (disp_rst_in)
    $changed(fr_r) |-> line_r == $past(st_disp_r)) // RULE_15
    else $error("line not preset on frame");
  // multi-step behaviours; byte strobe, column set and page set checks built from named sequences
  sequence ser_last_bit_s;
    ser_on && sclk_rise && bcnt_r == 3'h7;
  endsequence
  sequence ser_strobe_s;
    ser_vld_r ##1 !ser_vld_r;
  endsequence
  sequence col_cmd_s;
    cmd_go && (cval & LHP_CMD_COL_MASK) == LHP_CMD_COL;
  endsequence
  sequence page_cmd_s;
    cmd_go && (cval & LHP_CMD_PAGE_MASK) == LHP_CMD_PAGE;
  endsequence
  byte_pulse_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    ser_last_bit_s |=> ser_strobe_s) // RULE_07
    else $error("byte strobe not single");
  stat_bit_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    rd_start && !a0 |=> data_out == {$past(busy_out), 7'h00}) // RULE_14
    else $error("status byte wrong");
  col_set_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    col_cmd_s |=> col_r == $past(cval[6:0]) && $stable(page_r)) // RULE_19
    else $error("column set wrong");
  page_set_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    page_cmd_s |=> page_r == {2'b00, $past(cval[1:0])} && $stable(col_r)) // RULE_19
    else $error("page set wrong");
  ind_bit_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    dwr_go && !col_lock_r && page_r == LHP_IND_PAGE |=> ram_r[$past(widx)][7:1] == 7'h00) // RULE_21
    else $error("indicator row kept upper bits");
  oe_follow_a: assert property (@(posedge core_clk_in) disable iff (port_rst)
    rd_hold |=> data_oe_out) // RULE_03
    else $error("read not driven");
  line_step_a: assert property (@(posedge disp_clk_in) disable iff (disp_rst_in)
    step && line_r != 5'(LHP_LINES - 1) |=> line_r == $past(line_r) + 5'h01) // RULE_16
    else $error("line did not step");
  fr_wrap_a: assert property (@(posedge disp_clk_in) disable iff (disp_rst_in)
    $changed(fr_r) |-> $past(step) && $past(line_r) == 5'(LHP_LINES - 1)) // RULE_23
    else $error("frame toggled off wrap");
  st_load_a: assert property (@(posedge disp_clk_in) disable iff (disp_rst_in)
    st_req_s2_r != st_seen_r |=> st_disp_r == $past(st_data_r)) // RULE_15
    else $error("start line not taken");
endmodule : lhp_port

// ---- tb/lhp_host.sv ----
// microprocessor model driving the host port pins
`timescale 1ns/100ps
module lhp_host
(
  input wire logic core_clk_in, // core clock
  input wire logic [7:0] data_out_in, // device pin drive
  input wire logic data_oe_in, // device pin enable
  output logic cs_n_out, // active-low select
  output logic cs_out, // active-high select
  output logic dc_out, // 1 data, 0 command
  output logic rd_e_out, // read strobe or enable
  output logic wr_rw_out, // write strobe or read-not-write
  output logic [7:0] pins_out // resolved data pins
);
  logic ena_bus = 1'b0, ser = 1'b0, drv = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] last = 8'h00;
  // floating pins flip each cycle so a stale byte never reads as valid
  assign pins_out = data_oe_in ? data_out_in : (drv ? val : ~last);
  always @(posedge core_clk_in)
  begin
    last <= pins_out;
  end
  initial
  begin
    cs_n_out = 1'b1;
    cs_out = 1'b0;
    dc_out = 1'b0;
    rd_e_out = 1'b1;
    wr_rw_out = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic select(input logic on);
    @(negedge core_clk_in);
    cs_n_out = ~on;
    cs_out = on;
    repeat (4) @(negedge core_clk_in);
  endtask : select
  // strobe held 8 cycles, data kept 4 more after release
  task automatic access(input logic dc, input logic rd, input logic [7:0] v, output logic [7:0] got);
    @(negedge core_clk_in);
    dc_out = dc;
    if (!ser) val = v;
    drv = ~rd | ser;
    wr_rw_out = rd;
    rd_e_out = ena_bus | ~rd;
    repeat (8) @(negedge core_clk_in);
    got = data_out_in;
    rd_e_out = ~ena_bus;
    wr_rw_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    drv = ser;
    repeat (2) @(negedge core_clk_in);
  endtask : access
  // serial clock rests low between bytes
  task automatic shift(input logic dc, input logic [7:0] v, input int n);
    @(negedge core_clk_in);
    dc_out = dc;
    for (int i = 0; i < n; i++)
    begin
      val = {v[7 - i], 7'h00};
      repeat (4) @(negedge core_clk_in);
      val[6] = 1'b1;
      repeat (4) @(negedge core_clk_in);
    end
    val[6] = 1'b0;
    repeat (6) @(negedge core_clk_in);
  endtask : shift
endmodule : lhp_host

// ---- tb/tb.sv ----
// bench for the lcd host port block
`timescale 1ns/100ps
module tb;
  import lhp_pkg::*;
  logic core_clk_in = 1'b0;
  logic disp_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic disp_rst_in = 1'b1;
  logic strap_hi = 1'b0;
  logic strap_lo = 1'b1;
  logic master_mode = 1'b1;
  logic line_clk = 1'b0;
  logic cs_n, cs, dc, rd_e, wr_rw, oe, frame, seg, busy, f0;
  logic [7:0] pins, dout, latch, got;
  logic [4:0] line;
  logic [6:0] col;
  logic [3:0] page;
  int miscompares = 0;
  int compares = 0;
  int oe_cnt = 0;
  int o0 = 0;
  always @(posedge core_clk_in)
  begin
    if (oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
  end
  always #2 core_clk_in = ~core_clk_in;
  // offset keeps display edges off core edges
  always
  begin
    if ($time == 0) #0.7;
    #80 disp_clk_in = ~disp_clk_in;
  end
  lhp_host HOST (.core_clk_in(core_clk_in), .data_out_in(dout), .data_oe_in(oe), .cs_n_out(cs_n), .cs_out(cs),
    .dc_out(dc), .rd_e_out(rd_e), .wr_rw_out(wr_rw), .pins_out(pins));
  lhp_port DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .disp_clk_in(disp_clk_in),
    .disp_rst_in(disp_rst_in), .bus_strap_hi_in(strap_hi), .bus_strap_lo_in(strap_lo),
    .chip_select_low_active_n_in(cs_n), .chip_select_high_active_in(cs), .data_command_select_in(dc),
    .rd_e_in(rd_e), .wr_rw_in(wr_rw), .data_in(pins), .master_mode_in(master_mode), .line_clock_input_in(line_clk),
    .data_out(dout), .data_oe_out(oe), .frame_ac_signal_out(frame), .line_addr_out(line), .latch_out(latch),
    .seg_reverse_out(seg), .column_out(col), .page_out(page), .busy_out(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic io(input logic d, input logic r, input logic [7:0] v);
    HOST.access(d, r, v, got);
  endtask : io
  task automatic straps(input logic hi, input logic lo);
    @(negedge core_clk_in);
    strap_hi = hi;
    strap_lo = lo;
    repeat (6) @(negedge core_clk_in);
  endtask : straps
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge core_clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge disp_clk_in);
    disp_rst_in = 1'b0;
    HOST.select(1'b1);
    chk({1'b0, col}, 8'h00);
    io(1'b0, 1'b0, 8'hba);
    chk({4'h0, page}, 8'h02);
    io(1'b0, 1'b0, 8'h10);
    chk({5'h00, col[6:4]}, 8'h01);
    io(1'b1, 1'b0, 8'h5a);
    io(1'b1, 1'b0, 8'ha5);
    chk({1'b0, col}, 8'h12);
    io(1'b0, 1'b0, 8'h10);
    io(1'b1, 1'b1, 8'h00);
    io(1'b1, 1'b1, 8'h00);
    chk(got, 8'h5a);
    o0 = oe_cnt;
    io(1'b1, 1'b1, 8'h00);
    chk(got, 8'ha5);
    chk({7'h00, oe_cnt != o0}, 8'h01);
    chk({1'b0, col}, 8'h13);
    io(1'b0, 1'b1, 8'h00);
    chk(got & 8'h80, 8'h00);
    io(1'b0, 1'b0, 8'h50);
    io(1'b1, 1'b0, 8'h11);
    chk({1'b0, col}, 8'h50);
    io(1'b0, 1'b0, 8'h20);
    io(1'b1, 1'b0, 8'h11);
    chk({1'b0, col}, 8'h21);
    io(1'b0, 1'b0, 8'ha1);
    chk({7'h00, seg}, 8'h01);
    io(1'b0, 1'b0, 8'ha0);
    chk({7'h00, seg}, 8'h00);
    io(1'b0, 1'b0, 8'hbc);
    io(1'b0, 1'b0, 8'h00);
    io(1'b1, 1'b0, 8'hff);
    io(1'b0, 1'b0, 8'h00);
    io(1'b1, 1'b1, 8'h00);
    io(1'b1, 1'b1, 8'h00);
    chk(got, 8'h01);
    HOST.select(1'b0);
    o0 = oe_cnt;
    io(1'b0, 1'b0, 8'hb9);
    io(1'b1, 1'b1, 8'h00);
    chk({4'h0, page}, 8'h04);
    chk({7'h00, oe_cnt != o0}, 8'h00);
    HOST.ena_bus = 1'b1;
    straps(1'b1, 1'b1);
    HOST.access(1'b0, 1'b0, 8'h00, got);
    HOST.select(1'b1);
    io(1'b0, 1'b0, 8'hb8);
    chk({4'h0, page}, 8'h00);
    io(1'b0, 1'b0, 8'h00);
    io(1'b1, 1'b0, 8'h96);
    io(1'b0, 1'b0, 8'h10);
    io(1'b1, 1'b0, 8'h3c);
    io(1'b0, 1'b0, 8'h10);
    io(1'b1, 1'b1, 8'h00);
    io(1'b1, 1'b1, 8'h00);
    chk(got, 8'h3c);
    io(1'b0, 1'b0, 8'hc5);
    f0 = frame;
    for (int i = 0; i < 700 && frame === f0; i++)
      @(posedge disp_clk_in);
    #1;
    if (frame === f0)
    begin
      chk({7'h00, frame}, {7'h00, ~f0});
      end_of_test();
    end
    chk({3'h0, line}, 8'h05);
    // slave mode: line steps only on the line clock, latch follows the line
    @(negedge disp_clk_in);
    master_mode = 1'b0;
    disp_rst_in = 1'b1;
    repeat (3) @(negedge disp_clk_in);
    disp_rst_in = 1'b0;
    repeat (3) @(negedge disp_clk_in);
    chk({3'h0, line}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      line_clk = 1'b1;
      repeat (4) @(negedge disp_clk_in);
      line_clk = 1'b0;
      repeat (4) @(negedge disp_clk_in);
    end
    chk({3'h0, line}, 8'h03);
    chk(latch, 8'h96);
    HOST.select(1'b0);
    HOST.ser = 1'b1;
    HOST.drv = 1'b1;
    HOST.val = 8'h00;
    straps(1'b1, 1'b0);
    HOST.select(1'b1);
    HOST.shift(1'b0, 8'hb9, 3);
    HOST.select(1'b0);
    HOST.select(1'b1);
    HOST.shift(1'b0, 8'hba, 8);
    chk({4'h0, page}, 8'h02);
    HOST.shift(1'b0, 8'h05, 8);
    HOST.shift(1'b1, 8'h11, 8);
    chk({1'b0, col}, 8'h06);
    o0 = oe_cnt;
    io(1'b1, 1'b1, 8'h00);
    chk({7'h00, oe_cnt != o0}, 8'h00);
    straps(1'b0, 1'b0);
    chk({1'b0, col}, 8'h00);
    end_of_test();
  end
endmodule : tb
